// *** verilog/block_transfer_sequencer.sv ***
/*
  Load-multiple / store-multiple sequencer with an AXI4-Lite control port.
  Assumes: register file reads combinationally from rf_raddr, commits a
  write at the end of a cycle with rf_we high; memory answers mem_rdata and
  memory_fault_in in the same cycle as mem_req; all inputs share clk.
*/
// Contract
// - Bit i of the 16-bit list selects register i; list must be non-empty.
// - A stored program counter reads as instruction address plus twelve.
// - Registers move lowest first at lowest address; program counter last.
// - Addresses come from base, before/after and up/down bits; load bit selects.
// - Without write-back base keeps its value unless a load replaces it.
// - Unaligned base changes nothing; low address bits still driven.
// - Privileged load with program counter copies saved status into current.
// - Privileged store with program counter reads user bank; no write-back.
// - Privileged bit without program counter moves user bank registers.
// - No interlock after user-bank load; software adds a no-operation.
// - Base written back end of second cycle; store data starts then.
// - Stored base is original if first, updated if later.
// - Loaded base value beats written-back base unless the load aborts.
// - Aborts behave the same whatever late-abort select says.
// - Aborted store completes, then traps; only write-back changes state.
// - Aborted load stops register writes from the fault onward.
// - After aborted load base restored to written-back or original value.
// - Data abort trap only after aborted load completes.
// - Load n+2 cycles, with program counter n+4, store n+1.
// - Full/empty, ascending/descending stacks through before and up bits.
`default_nettype none

module block_transfer_sequencer (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr_word,
  input  wire logic [31:0] instr_addr,
  input  wire logic [31:0] base_value,
  output logic             instr_ready,
  output logic             instr_done,
  output logic             abort_trap,
  output logic [3:0]       rf_raddr,
  output logic             rf_ruser,
  input  wire logic [31:0] rf_rdata,
  output logic             rf_we,
  output logic [3:0]       rf_waddr,
  output logic [31:0]      rf_wdata,
  output logic             rf_wuser,
  output logic             status_restore,
  output logic             mem_req,
  output logic             mem_write,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        memory_fault_in,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ------------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------------
  function automatic logic [4:0] count_ones(input logic [15:0] list);
    logic [4:0] n;
    n = 5'h0;
    for (int i = 0; i < block_transfer_pkg::LIST_WIDTH; i++) begin
      n = n + {4'h0, list[i]};
    end
    return n;
  endfunction : count_ones

  function automatic logic [3:0] lowest_index(input logic [15:0] list);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = block_transfer_pkg::LIST_WIDTH - 1; i >= 0; i--) begin
      if (list[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : lowest_index

  function automatic block_transfer_pkg::reg_sel_type reg_select(input logic [7:0] addr);
    unique case (addr)
      block_transfer_pkg::CTRL_OFFSET:   return block_transfer_pkg::REG_CTRL;
      block_transfer_pkg::STATUS_OFFSET: return block_transfer_pkg::REG_STATUS;
      block_transfer_pkg::COUNT_OFFSET:  return block_transfer_pkg::REG_COUNT;
      default:                           return block_transfer_pkg::REG_NONE;
    endcase
  endfunction : reg_select

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  block_transfer_pkg::seq_state_type state_q;
  logic [15:0] list_q;
  logic [3:0]  cur_q;
  logic [3:0]  base_idx_q;
  logic        load_q;
  logic        wback_q;
  logic        priv_q;
  logic        user_q;
  logic        pcload_q;
  logic        abort_q;
  logic        last_abort_q;
  logic [1:0]  refill_q;
  logic [31:0] addr_q;
  logic [31:0] orig_q;
  logic [31:0] wb_q;
  logic [31:0] pc12_q;
  logic        instr_ready_q;
  logic        instr_done_q;
  logic        abort_trap_q;
  logic [3:0]  rf_raddr_q;
  logic        rf_we_q;
  logic [3:0]  rf_waddr_q;
  logic [31:0] rf_wdata_q;
  logic        rf_wuser_q;
  logic        status_restore_q;
  logic        mem_req_q;
  logic        mem_write_q;
  logic [31:0] mem_addr_q;
  logic [31:0] mem_wdata_q;
  logic [1:0]  ctrl_q;
  logic [31:0] count_q;
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;

  logic        accept;
  logic        issue;
  logic        done_now;
  logic [15:0] next_list;
  logic [3:0]  next_idx;
  logic [31:0] store_data;
  logic [4:0]  in_count;
  logic [31:0] in_span;
  logic [31:0] in_low;
  logic [31:0] in_wb;

  // ------------------------------------------------------------------
  // Decode of an incoming instruction
  // ------------------------------------------------------------------
  always_comb begin
    in_count = count_ones(instr_word[15:0]);
    in_span  = {25'h0, in_count, 2'h0};
    if (instr_word[block_transfer_pkg::UP_BIT]) begin
      in_wb  = base_value + in_span;
      in_low = instr_word[block_transfer_pkg::BEFORE_BIT] ?
               base_value + block_transfer_pkg::WORD_BYTES : base_value;
    end else begin
      in_wb  = base_value - in_span;
      in_low = instr_word[block_transfer_pkg::BEFORE_BIT] ?
               in_wb : in_wb + block_transfer_pkg::WORD_BYTES;
    end
  end

  // Sequencing terms
  assign accept    = (state_q == block_transfer_pkg::ST_IDLE) && instr_valid && instr_ready_q;
  assign next_list = list_q & (list_q - 16'h0001);
  assign next_idx  = lowest_index(list_q);
  assign issue     = (state_q == block_transfer_pkg::ST_SETUP) ||
                     ((state_q == block_transfer_pkg::ST_XFER) && (list_q != 16'h0000));
  assign done_now  = ((state_q == block_transfer_pkg::ST_XFER) && (list_q == 16'h0000) && !load_q) ||
                     ((state_q == block_transfer_pkg::ST_FINISH) && !(pcload_q && !abort_q)) ||
                     ((state_q == block_transfer_pkg::ST_REFILL) && (refill_q == 2'h1));

  // Store data: program counter offset, bypassed new base, or bank read
  always_comb begin
    if (next_idx == block_transfer_pkg::PC_INDEX) begin
      store_data = pc12_q;
    end else if ((next_idx == base_idx_q) && wback_q &&
                 (state_q == block_transfer_pkg::ST_XFER)) begin
      store_data = wb_q;
    end else begin
      store_data = rf_rdata;
    end
  end

  // ------------------------------------------------------------------
  // Transfer sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q          <= block_transfer_pkg::ST_IDLE;
      list_q           <= 16'h0000;
      cur_q            <= 4'h0;
      base_idx_q       <= 4'h0;
      load_q           <= 1'b0;
      wback_q          <= 1'b0;
      priv_q           <= 1'b0;
      user_q           <= 1'b0;
      pcload_q         <= 1'b0;
      abort_q          <= 1'b0;
      last_abort_q     <= 1'b0;
      refill_q         <= 2'h0;
      addr_q           <= 32'h00000000;
      orig_q           <= 32'h00000000;
      wb_q             <= 32'h00000000;
      pc12_q           <= 32'h00000000;
      instr_ready_q    <= 1'b0;
      instr_done_q     <= 1'b0;
      abort_trap_q     <= 1'b0;
      rf_raddr_q       <= 4'h0;
      rf_we_q          <= 1'b0;
      rf_waddr_q       <= 4'h0;
      rf_wdata_q       <= 32'h00000000;
      rf_wuser_q       <= 1'b0;
      status_restore_q <= 1'b0;
      mem_req_q        <= 1'b0;
      mem_write_q      <= 1'b0;
      mem_addr_q       <= 32'h00000000;
      mem_wdata_q      <= 32'h00000000;
    end else begin
      rf_we_q          <= 1'b0;
      status_restore_q <= 1'b0;
      instr_done_q     <= 1'b0;
      abort_trap_q     <= 1'b0;
      unique case (state_q)
        block_transfer_pkg::ST_IDLE: begin
          instr_ready_q <= ctrl_q[block_transfer_pkg::CTRL_ENABLE_BIT] && !accept;
          if (accept) begin
            list_q     <= instr_word[15:0];
            base_idx_q <= instr_word[block_transfer_pkg::BASE_LSB +: 4];
            load_q     <= instr_word[block_transfer_pkg::LOAD_BIT];
            wback_q    <= instr_word[block_transfer_pkg::WRITEBACK_BIT];
            priv_q     <= instr_word[block_transfer_pkg::PRIV_BANK_BIT];
            user_q     <= instr_word[block_transfer_pkg::PRIV_BANK_BIT] &&
                          !(instr_word[block_transfer_pkg::LOAD_BIT] && instr_word[15]);
            pcload_q   <= instr_word[block_transfer_pkg::LOAD_BIT] && instr_word[15];
            abort_q    <= 1'b0;
            addr_q     <= in_low;
            orig_q     <= base_value;
            wb_q       <= in_wb;
            pc12_q     <= instr_addr + block_transfer_pkg::PC_STORE_OFFSET;
            rf_raddr_q <= lowest_index(instr_word[15:0]);
            state_q    <= block_transfer_pkg::ST_SETUP;
          end
        end
        block_transfer_pkg::ST_SETUP: begin
          // Base write-back lands at the end of the second cycle
          rf_we_q    <= wback_q;
          rf_waddr_q <= base_idx_q;
          rf_wdata_q <= wb_q;
          rf_wuser_q <= 1'b0;
          state_q    <= block_transfer_pkg::ST_XFER;
        end
        block_transfer_pkg::ST_XFER: begin
          // Fault sampled on every transfer, same path whatever the late-abort bit
          if (load_q) begin
            if (memory_fault_in || abort_q) begin
              abort_q <= 1'b1;
            end else begin
              rf_we_q          <= 1'b1;
              rf_waddr_q       <= cur_q;
              rf_wdata_q       <= mem_rdata;
              rf_wuser_q       <= user_q;
              status_restore_q <= (cur_q == block_transfer_pkg::PC_INDEX) && priv_q;
            end
          end else if (memory_fault_in) begin
            abort_q <= 1'b1;
          end
          if ((list_q == 16'h0000) && load_q) begin
            state_q <= block_transfer_pkg::ST_FINISH;
          end
        end
        block_transfer_pkg::ST_FINISH: begin
          if (abort_q) begin
            rf_we_q    <= 1'b1;
            rf_waddr_q <= base_idx_q;
            rf_wdata_q <= wback_q ? wb_q : orig_q;
            rf_wuser_q <= 1'b0;
          end else if (pcload_q) begin
            refill_q <= block_transfer_pkg::REFILL_CYCLES;
            state_q  <= block_transfer_pkg::ST_REFILL;
          end
        end
        block_transfer_pkg::ST_REFILL: begin
          refill_q <= refill_q - 2'h1;
        end
        default: begin
          state_q <= block_transfer_pkg::ST_IDLE;
        end
      endcase
      // Issue one transfer per cycle; stores keep going after a fault
      if (issue) begin
        mem_req_q   <= 1'b1;
        mem_write_q <= !load_q;
        mem_addr_q  <= addr_q;
        mem_wdata_q <= store_data;
        cur_q       <= next_idx;
        list_q      <= next_list;
        addr_q      <= addr_q + block_transfer_pkg::WORD_BYTES;
        rf_raddr_q  <= lowest_index(next_list);
      end else begin
        mem_req_q   <= 1'b0;
      end
      // Trap only once the whole instruction has run
      if (done_now) begin
        state_q       <= block_transfer_pkg::ST_IDLE;
        instr_done_q  <= 1'b1;
        abort_trap_q  <= abort_q || (!load_q && memory_fault_in);
        last_abort_q  <= abort_q || (!load_q && memory_fault_in);
        instr_ready_q <= ctrl_q[block_transfer_pkg::CTRL_ENABLE_BIT];
      end
    end
  end

  // ------------------------------------------------------------------
  // Control register and completion counter
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= block_transfer_pkg::CTRL_RESET;
    end else if (!awready_q && !wready_q && !bvalid_q && wstrb_q[0] &&
                 (reg_select(awaddr_q) == block_transfer_pkg::REG_CTRL)) begin
      ctrl_q <= wdata_q[1:0];                                        // Late-abort bit is stored only
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_q <= 32'h00000000;
    end else if (instr_done_q) begin
      count_q <= count_q + 32'h00000001;
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite write channel: address and data taken in either order
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= block_transfer_pkg::RESP_OKAY;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
    end else begin
      if (awready_q && s_axi_awvalid) begin
        awready_q <= 1'b0;
        awaddr_q  <= s_axi_awaddr;
      end
      if (wready_q && s_axi_wvalid) begin
        wready_q <= 1'b0;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (!awready_q && !wready_q && !bvalid_q) begin
        bvalid_q <= 1'b1;
        bresp_q  <= (reg_select(awaddr_q) == block_transfer_pkg::REG_NONE) ?
                    block_transfer_pkg::RESP_SLVERR : block_transfer_pkg::RESP_OKAY;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite read channel
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= block_transfer_pkg::RESP_OKAY;
      rdata_q   <= 32'h00000000;
    end else if (arready_q && s_axi_arvalid) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= block_transfer_pkg::RESP_OKAY;
      unique case (reg_select(s_axi_araddr))
        block_transfer_pkg::REG_CTRL:   rdata_q <= {30'h0, ctrl_q};
        block_transfer_pkg::REG_STATUS: rdata_q <= {30'h0, last_abort_q,
                                                    state_q != block_transfer_pkg::ST_IDLE};
        block_transfer_pkg::REG_COUNT:  rdata_q <= count_q;
        block_transfer_pkg::REG_NONE: begin
          rdata_q <= 32'h00000000;
          rresp_q <= block_transfer_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Outputs straight from flip-flops
  // ------------------------------------------------------------------
  assign instr_ready    = instr_ready_q;
  assign instr_done     = instr_done_q;
  assign abort_trap     = abort_trap_q;
  assign rf_raddr       = rf_raddr_q;
  assign rf_ruser       = user_q;
  assign rf_we          = rf_we_q;
  assign rf_waddr       = rf_waddr_q;
  assign rf_wdata       = rf_wdata_q;
  assign rf_wuser       = rf_wuser_q;
  assign status_restore = status_restore_q;
  assign mem_req        = mem_req_q;
  assign mem_write      = mem_write_q;
  assign mem_addr       = mem_addr_q;
  assign mem_wdata      = mem_wdata_q;
  assign s_axi_awready  = awready_q;
  assign s_axi_wready   = wready_q;
  assign s_axi_bvalid   = bvalid_q;
  assign s_axi_bresp    = bresp_q;
  assign s_axi_arready  = arready_q;
  assign s_axi_rvalid   = rvalid_q;
  assign s_axi_rresp    = rresp_q;
  assign s_axi_rdata    = rdata_q;

endmodule : block_transfer_sequencer

`default_nettype wire

// *** verilog/block_transfer_pkg.sv ***
/*
  Constants and types for the block transfer sequencer: instruction
  field positions, transfer constants, register map and sequencer states.
  Assumes: compiled before any file that names block_transfer_pkg.
*/
`default_nettype none

package block_transfer_pkg;

  // ------------------------------------------------------------------
  // Instruction fields
  // ------------------------------------------------------------------
  localparam int          LIST_WIDTH      = 16;
  localparam int          BASE_LSB        = 16;
  localparam int          LOAD_BIT        = 20;
  localparam int          WRITEBACK_BIT   = 21;
  localparam int          PRIV_BANK_BIT   = 22;
  localparam int          UP_BIT          = 23;
  localparam int          BEFORE_BIT      = 24;
  localparam logic [3:0]  PC_INDEX        = 4'hf;

  // ------------------------------------------------------------------
  // Transfer constants
  // ------------------------------------------------------------------
  localparam logic [31:0] PC_STORE_OFFSET = 32'h0000000c;
  localparam logic [31:0] WORD_BYTES      = 32'h00000004;
  localparam logic [1:0]  REFILL_CYCLES   = 2'h2;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFFSET     = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET   = 8'h04;
  localparam logic [7:0]  COUNT_OFFSET    = 8'h08;
  localparam int          CTRL_ENABLE_BIT = 0;
  localparam int          CTRL_LATE_BIT   = 1;
  localparam logic [1:0]  CTRL_RESET      = 2'h1;
  localparam int          STAT_BUSY_BIT   = 0;
  localparam int          STAT_ABORT_BIT  = 1;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [1:0] {
    REG_CTRL   = 2'h0,
    REG_STATUS = 2'h1,
    REG_COUNT  = 2'h2,
    REG_NONE   = 2'h3
  } reg_sel_type;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_SETUP  = 3'h1,
    ST_XFER   = 3'h3,
    ST_FINISH = 3'h2,
    ST_REFILL = 3'h6
  } seq_state_type;

endpackage : block_transfer_pkg

`default_nettype wire

// *** dv/block_transfer_monitor.sv ***
/* Port checker for block_transfer_sequencer.
   Assumes one clock, bound by port name. */
`default_nettype none
module block_transfer_monitor (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        instr_valid,
  input wire logic        instr_ready,
  input wire logic [31:0] instr_word,
  input wire logic        instr_done,
  input wire logic        abort_trap,
  input wire logic        rf_we,
  input wire logic [3:0]  rf_waddr,
  input wire logic        status_restore,
  input wire logic        mem_req,
  input wire logic        mem_write,
  input wire logic [31:0] mem_addr,
  input wire logic        memory_fault_in
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [5:0] cnt_q, need_q;
  logic       load_q;
  wire        take = instr_valid && instr_ready;
  sequence take_store; take && !instr_word[20]; endsequence
  sequence gap_then_req; !mem_req ##1 mem_req; endsequence
  // Cycles since acceptance
  always_ff @(posedge clk or posedge reset)
    if (reset) cnt_q <= 6'h0;
    else cnt_q <= take ? 6'h1 : cnt_q + 6'h1;
  // Expected length and direction, caught at acceptance
  always_ff @(posedge clk or posedge reset)
    if (reset) {need_q, load_q} <= 7'h0;
    else if (take) {need_q, load_q} <= {6'($countones(instr_word[15:0]))
      + (instr_word[20] ? (instr_word[15] ? 6'h4 : 6'h2) : 6'h1), instr_word[20]};
  // Busy cycles are 1..need_q after the take edge; the done pulse shows in the cycle after them
  a_len_exact: assert property (instr_done && !abort_trap |-> cnt_q == need_q + 6'h1) else $error("bad length");
  a_done_once: assert property (instr_done |=> !instr_done) else $error("long done");
  a_trap_at_end: assert property (abort_trap |-> instr_done) else $error("early trap");
  a_addr_step: assert property (mem_req && $past(mem_req) |-> mem_addr == $past(mem_addr) + 32'h4)
    else $error("bad step");
  a_dir_kept: assert property (mem_req |-> mem_write == !load_q) else $error("bad direction");
  a_store_second: assert property (take_store |=> gap_then_req) else $error("bad store start");
  a_restore_pc: assert property (status_restore |-> rf_we && rf_waddr == 4'hf) else $error("bad restore");
  a_fault_stops: assert property (mem_req && !mem_write && memory_fault_in |=> !rf_we || instr_done)
    else $error("load after fault");
endmodule : block_transfer_monitor
bind block_transfer_sequencer block_transfer_monitor mon (.*);
`default_nettype wire

// *** dv/mem_partner.sv ***
/* Memory and memory manager model.
   Assumes an answer in the mem_req cycle. */
`default_nettype none
module mem_partner (
  input wire logic [31:0] mem_addr,
  input wire logic        mem_req,
  input wire logic [31:0] fault_addr,
  output logic [31:0]     mem_rdata,
  output logic            memory_fault_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Load data is the inverted address; an idle bus shows another pattern
  assign mem_rdata = mem_req ? ~mem_addr : mem_addr;
  // One chosen address is rejected
  assign memory_fault_in = mem_req && mem_addr == fault_addr;
  // Stores are never kept, so none lands after a fault
endmodule : mem_partner
`default_nettype wire

// *** dv/block_transfer_sequencer_tb.sv ***
/* Random and corner bench for block_transfer_sequencer.
   Assumes mem_partner and the bound checker. */
`default_nettype none
module block_transfer_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, reset = 1'b1, instr_valid = 1'b0, rf_ruser, rf_we, rf_wuser, status_restore;
  logic [31:0] instr_word = 32'h0, instr_addr = 32'h0, base_value = 32'h0, fault_addr = 32'h0, seed = 32'h7619;
  logic        instr_ready, instr_done, abort_trap, mem_req, mem_write, memory_fault_in;
  logic [3:0]  rf_raddr, rf_waddr, s_axi_wstrb = 4'hf;
  logic [31:0] rf_rdata, rf_wdata, mem_addr, mem_wdata, mem_rdata, s_axi_wdata = 32'h0, s_axi_rdata, regs [16];
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          failures = 0, total_checks = 0;
  block_transfer_sequencer DUT (.*);
  mem_partner P (.*);
  // Register file: the base reads its held value, others answer with bank flag and index
  assign rf_rdata = (rf_raddr == instr_word[19:16]) ? regs[rf_raddr] : {rf_ruser, 27'h0, rf_raddr};
  always #10 clk = ~clk;
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  // One AXI4-Lite write or read, each channel released when taken
  task axi(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic [1:0] rs);
    int i;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {wr, wr, wr, !wr, !wr};
    for (i = 0; i < 50 && (i == 0 || s_axi_bready || s_axi_rready); i++) begin
      @(posedge clk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) s_axi_bready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rready <= 1'b0;
        q = s_axi_rdata;
        rs = s_axi_rresp;
      end
    end
    if (i == 50) failures++;
  endtask : axi
  // Offer one instruction, follow the bus, then compare registers
  task run(input logic [31:0] w, input logic [31:0] b, input int kf);
    int n, k, i, r;
    logic [31:0] lo, wb, e;
    n = $countones(w[15:0]);
    wb = w[23] ? b + 32'(4 * n) : b - 32'(4 * n);
    lo = w[23] ? b + (w[24] ? 32'h4 : 32'h0) : b - 32'(4 * n) + (w[24] ? 32'h0 : 32'h4);
    for (i = 0; i < 16; i++) regs[i] = 32'hc0de0000 + 32'(i);
    regs[w[19:16]] = b;
    {fault_addr, instr_word, base_value, instr_addr, instr_valid} <= {lo + 32'(4 * kf), w, b, seed, 1'b1};
    k = 0;
    r = -1;
    for (i = 0; i < 64; i++) begin
      @(posedge clk);
      if (instr_ready && instr_valid) instr_valid <= 1'b0;
      if (mem_req) begin
        check(mem_addr, lo + 32'(4 * k));
        r++;
        while (!w[r]) r++;
        if (mem_write) check(mem_wdata, r == 15 ? instr_addr + 32'hc : 4'(r) == w[19:16] ?
          (k == 0 || !w[21] ? b : wb) : {w[22], 27'h0, 4'(r)});
        k++;
      end
      if (rf_we) regs[rf_waddr] = rf_wdata;
      if (rf_we && w[20] && rf_waddr != w[19:16]) check(32'(rf_wuser), 32'(w[22] && !w[15]));
      if (instr_done) break;
    end
    if (i == 64) failures++;
    check(32'(abort_trap), 32'(kf < n));
    for (i = 0; i < 16; i++) begin
      k = $countones(w[15:0] & ~(16'hffff << i));
      e = w[20] && w[i] && k < kf ? ~(lo + 32'(4 * k)) : 32'hc0de0000 + 32'(i);
      if (4'(i) == w[19:16]) e = w[20] && w[i] && kf >= n ? ~(lo + 32'(4 * k)) : w[21] ? wb : b;
      check(regs[i], e);
    end
  endtask : run
  initial begin
    logic [31:0] w, q;
    logic [1:0] rs;
    int j;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    axi(1'b1, 8'h00, 32'h3, q, rs);
    axi(1'b0, 8'h00, 32'h0, q, rs);
    check(q, 32'h3);
    // Full store with base, privileged load with PC, aborted load, then random
    for (j = 0; j < 40; j++) begin
      seed = xs(seed);
      w = seed & 32'h01ffffff;
      w[19:16] = w[19:16] == 4'hf ? 4'he : w[19:16];
      if (w[22]) {w[21], w[w[19:16]]} = 2'h0;
      w[w[19:16] ^ 4'h1] = 1'b1;
      w = j == 0 ? 32'h00a0ffff : j == 1 ? 32'h01d28003 : j == 2 ? 32'h003300f8 : w;
      run(w, xs(seed), j < 2 ? 31 : j == 2 ? 2 : int'(seed[29:25]));
    end
    axi(1'b0, 8'h08, 32'h0, q, rs);
    check(q, 32'h28);
    axi(1'b0, 8'h10, 32'h0, q, rs);
    check({q, 30'h0, rs}, {32'h0, 32'h2});
    close_out();
  end
endmodule : block_transfer_sequencer_tb
`default_nettype wire
